// File: verilog/plsd_pkg.sv
// Notes on behaviour
// - a parity error in a packet for the configuration space raises a flag, after which the application must reset the core.
// - a corrected receive-buffer error is a pulse, stretched from the fast internal domain so fabric logic can catch it.
// - a corrected ECC error in the retry buffer shows on its own debug output and needs no action.
// - an uncorrectable retry-buffer error shows on a separate debug output.
// - data-link-up stays high for as long as the data link control machine is in its up state.
// - leaving the link-up state drives data-link-exit low for exactly one user-clock cycle.
// - a tick pulses once every 128 ns.
// - a second tick pulses once every 1 us.
// - hot-reset exit, active low, drops for one cycle when training leaves the hot reset state.
// - L2 exit idles high and drops for one cycle when training moves from L2 idle to detect.
// - the four legacy interrupts appear on four bits, A on bit 0 through D on bit 3.
// - the negotiated lane count appears one-hot: 0001 one lane, 0100 two, 1000 four.
// - the current link training state appears on five bits, e.g. 00000 detect quiet, 01111 L0, 10100 hot reset.
package plsd_pkg;

   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_SHORT_NS = 128;
   localparam int TICK_LONG_NS = 1000;

   localparam logic [4:0] LT_DETECT_QUIET = 5'h00;
   localparam logic [4:0] LT_DETECT_ACTIVE = 5'h01;
   localparam logic [4:0] LT_L0 = 5'h0F;
   localparam logic [4:0] LT_HOT_RESET = 5'h14;
   localparam logic [4:0] LT_L2_IDLE = 5'h15;

   localparam logic [3:0] LANE_X1 = 4'h1;
   localparam logic [3:0] LANE_X2 = 4'h4;
   localparam logic [3:0] LANE_X4 = 4'h8;

   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_EVENT = 4'h4;
   localparam logic [3:0] ADDR_MASK = 4'h8;
   localparam logic [3:0] ADDR_CONTROL = 4'hC;

   localparam int ST_DLUP_BIT = 0;
   localparam int ST_CFGERR_BIT = 1;
   localparam int ST_LTSSM_LSB = 4;
   localparam int ST_LANE_LSB = 12;
   localparam int ST_INT_LSB = 16;
   localparam int CTL_TICK_EN_BIT = 0;

   localparam int EVT_W = 7;
   localparam logic [6:0] MASK_RST = 7'h00;
   localparam logic [6:0] EVENT_RST = 7'h00;
   localparam logic CTL_TICK_EN_RST = 1'b1;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic l2_exit;
      logic hot_exit;
      logic dl_exit;
      logic rpl_uncor;
      logic rpl_cor;
      logic rcv_cor;
      logic cfg_par;
   } plsd_evt_s;

   typedef struct packed {
      logic [4:0] ltssm;
      logic [3:0] lane;
      logic [3:0] intx;
      logic dl_up;
      logic rpl_uncor;
      logic rpl_cor;
      logic rcv_cor;
      logic cfg_par;
   } plsd_core_s;

endpackage

// File: verilog/plsd_top.sv
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module plsd_top #(
   parameter int ADDR_W = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire plsd_pkg::plsd_core_s core_in,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic cfg_par_err,
   output logic rcv_cor_err,
   output logic rpl_cor_err,
   output logic rpl_uncor_err,
   output logic dl_up,
   output logic dl_exit_n,
   output logic tick_128_nanosecond,
   output logic tick_1_microsecond,
   output logic hot_reset_exit_n,
   output logic l2_exit_n,
   output logic [3:0] int_status,
   output logic [3:0] lane_act,
   output logic [4:0] ltssm_state,
   output logic irq
);

   localparam logic [7:0] STEP_S = 8'(plsd_pkg::CLK_PERIOD_NS);
   localparam logic [7:0] PER_S = 8'(plsd_pkg::TICK_SHORT_NS);
   localparam logic [9:0] STEP_L = 10'(plsd_pkg::CLK_PERIOD_NS);
   localparam logic [9:0] PER_L = 10'(plsd_pkg::TICK_LONG_NS);

   function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                    input logic [3:0] off);
      reg_hit = (a == ADDR_W'(off));
   endfunction

   function automatic logic [3:0] lane_clean(input logic [3:0] l);
      lane_clean = (l == plsd_pkg::LANE_X1 || l == plsd_pkg::LANE_X2 ||
                    l == plsd_pkg::LANE_X4) ? l : 4'h0;
   endfunction

   // a code counts only once two synced samples agree
   function automatic logic [4:0] settled(input logic [4:0] cur,
                                          input logic [4:0] last,
                                          input logic [4:0] held);
      settled = (cur == last) ? cur : held;
   endfunction

   // monitor state
   plsd_pkg::plsd_core_s sync1, sync2, prev;
   plsd_pkg::plsd_core_s next_sync1, next_sync2, next_prev;
   logic [7:0] acc_s, next_acc_s;
   logic [9:0] acc_l, next_acc_l;
   logic next_cfg_par_err, next_rcv_cor_err, next_rpl_cor_err;
   logic next_rpl_uncor_err, next_dl_up, next_dl_exit_n;
   logic next_tick_s, next_tick_l, next_hot_n, next_l2_n;
   logic [3:0] next_int_status, next_lane_act;
   logic [4:0] next_ltssm_state;
   plsd_pkg::plsd_evt_s evt_new;
   logic ctl_tick_en, next_ctl_tick_en;
   logic [4:0] lt_ok, next_lt_ok, lt_last, next_lt_last;
   logic [3:0] lane_ok, next_lane_ok, int_ok, next_int_ok;

   always_comb begin
      next_sync1 = core_in;
      next_sync2 = sync1;
      next_prev = sync2;
      // a torn code across the crossing could fake an exit pulse
      next_lt_ok = settled(sync2.ltssm, prev.ltssm, lt_ok);
      next_lt_last = lt_ok;
      next_lane_ok = 4'(settled(5'(sync2.lane), 5'(prev.lane), 5'(lane_ok)));
      next_int_ok = 4'(settled(5'(sync2.intx), 5'(prev.intx), 5'(int_ok)));
      evt_new = '0;
      evt_new.cfg_par = sync2.cfg_par & ~prev.cfg_par;
      evt_new.rcv_cor = sync2.rcv_cor & ~prev.rcv_cor;
      evt_new.rpl_cor = sync2.rpl_cor & ~prev.rpl_cor;
      evt_new.rpl_uncor = sync2.rpl_uncor & ~prev.rpl_uncor;
      evt_new.dl_exit = prev.dl_up & ~sync2.dl_up;
      evt_new.hot_exit = (lt_last == plsd_pkg::LT_HOT_RESET) &&
                         (lt_ok != plsd_pkg::LT_HOT_RESET);
      evt_new.l2_exit = (lt_last == plsd_pkg::LT_L2_IDLE) &&
                        (lt_ok == plsd_pkg::LT_DETECT_QUIET ||
                         lt_ok == plsd_pkg::LT_DETECT_ACTIVE);
      // sticky until the application resets the core
      next_cfg_par_err = cfg_par_err | evt_new.cfg_par;
      // input arrives already stretched; trimmed to one user-clock pulse
      next_rcv_cor_err = evt_new.rcv_cor;
      next_rpl_cor_err = sync2.rpl_cor;
      next_rpl_uncor_err = sync2.rpl_uncor;
      next_dl_up = sync2.dl_up;
      next_dl_exit_n = ~evt_new.dl_exit;
      next_hot_n = ~evt_new.hot_exit;
      next_l2_n = ~evt_new.l2_exit;
      next_int_status = int_ok;
      next_lane_act = lane_clean(lane_ok);
      next_ltssm_state = lt_ok;
      // ns accumulators keep the exact average period for whole-ns clock periods up to 24 ns
      next_tick_s = 1'b0;
      next_tick_l = 1'b0;
      next_acc_s = acc_s + STEP_S;
      next_acc_l = acc_l + STEP_L;
      if (next_acc_s >= PER_S) begin
         next_acc_s = next_acc_s - PER_S;
         next_tick_s = 1'b1;
      end
      if (next_acc_l >= PER_L) begin
         next_acc_l = next_acc_l - PER_L;
         next_tick_l = 1'b1;
      end
      if (!ctl_tick_en) begin
         next_acc_s = 8'h00;
         next_acc_l = 10'h000;
         next_tick_s = 1'b0;
         next_tick_l = 1'b0;
      end
   end

   // all outputs leave on aclk flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1 <= '0;
         sync2 <= '0;
         prev <= '0;
         acc_s <= 8'h00;
         acc_l <= 10'h000;
         cfg_par_err <= 1'b0;
         rcv_cor_err <= 1'b0;
         rpl_cor_err <= 1'b0;
         rpl_uncor_err <= 1'b0;
         dl_up <= 1'b0;
         dl_exit_n <= 1'b1;
         tick_128_nanosecond <= 1'b0;
         tick_1_microsecond <= 1'b0;
         hot_reset_exit_n <= 1'b1;
         l2_exit_n <= 1'b1;
         int_status <= 4'h0;
         lane_act <= 4'h0;
         ltssm_state <= 5'h00;
         lt_ok <= 5'h00;
         lt_last <= 5'h00;
         lane_ok <= 4'h0;
         int_ok <= 4'h0;
      end else begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
         prev <= next_prev;
         acc_s <= next_acc_s;
         acc_l <= next_acc_l;
         cfg_par_err <= next_cfg_par_err;
         rcv_cor_err <= next_rcv_cor_err;
         rpl_cor_err <= next_rpl_cor_err;
         rpl_uncor_err <= next_rpl_uncor_err;
         dl_up <= next_dl_up;
         dl_exit_n <= next_dl_exit_n;
         tick_128_nanosecond <= next_tick_s;
         tick_1_microsecond <= next_tick_l;
         hot_reset_exit_n <= next_hot_n;
         l2_exit_n <= next_l2_n;
         int_status <= next_int_status;
         lane_act <= next_lane_act;
         ltssm_state <= next_ltssm_state;
         lt_ok <= next_lt_ok;
         lt_last <= next_lt_last;
         lane_ok <= next_lane_ok;
         int_ok <= next_int_ok;
      end
   end

   // register bus state
   logic [6:0] mask, next_mask;
   logic [6:0] event_q, next_event_q;
   logic aw_have, next_aw_have, w_have, next_w_have;
   logic [ADDR_W-1:0] aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic w_lane0, next_w_lane0;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata, status_word;
   logic next_irq;
   logic [6:0] rd_clr;

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[plsd_pkg::ST_DLUP_BIT] = dl_up;
      status_word[plsd_pkg::ST_CFGERR_BIT] = cfg_par_err;
      status_word[plsd_pkg::ST_LTSSM_LSB +: 5] = ltssm_state;
      status_word[plsd_pkg::ST_LANE_LSB +: 4] = lane_act;
      status_word[plsd_pkg::ST_INT_LSB +: 4] = int_status;
   end

   always_comb begin
      next_aw_have = aw_have | (s_axi_awvalid & s_axi_awready);
      next_w_have = w_have | (s_axi_wvalid & s_axi_wready);
      next_aw_addr = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : aw_addr;
      next_w_data = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : w_data;
      next_w_lane0 = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb[0] : w_lane0;
      next_bvalid = s_axi_bvalid & ~s_axi_bready;
      next_bresp = s_axi_bresp;
      next_mask = mask;
      next_ctl_tick_en = ctl_tick_en;
      // both halves held: commit once, then refuse new ones until b taken
      if (aw_have && w_have && !s_axi_bvalid) begin
         next_aw_have = 1'b0;
         next_w_have = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = plsd_pkg::RESP_OKAY;
         if (reg_hit(aw_addr, plsd_pkg::ADDR_MASK)) begin
            if (w_lane0)
               next_mask = w_data[6:0];
         end else if (reg_hit(aw_addr, plsd_pkg::ADDR_CONTROL)) begin
            if (w_lane0)
               next_ctl_tick_en = w_data[plsd_pkg::CTL_TICK_EN_BIT];
         end else if (!reg_hit(aw_addr, plsd_pkg::ADDR_STATUS) &&
                      !reg_hit(aw_addr, plsd_pkg::ADDR_EVENT)) begin
            next_bresp = plsd_pkg::RESP_SLVERR;
         end
      end
      next_awready = ~next_aw_have & ~next_bvalid;
      next_wready = ~next_w_have & ~next_bvalid;

      rd_clr = 7'h00;
      next_rvalid = s_axi_rvalid & ~s_axi_rready;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp = plsd_pkg::RESP_OKAY;
         next_rdata = 32'h0000_0000;
         if (reg_hit(s_axi_araddr, plsd_pkg::ADDR_STATUS)) begin
            next_rdata = status_word;
         end else if (reg_hit(s_axi_araddr, plsd_pkg::ADDR_EVENT)) begin
            next_rdata = {25'h0000000, event_q};
            rd_clr = event_q;
         end else if (reg_hit(s_axi_araddr, plsd_pkg::ADDR_MASK)) begin
            next_rdata = {25'h0000000, mask};
         end else if (reg_hit(s_axi_araddr, plsd_pkg::ADDR_CONTROL)) begin
            next_rdata = {31'h00000000, ctl_tick_en};
         end else begin
            next_rresp = plsd_pkg::RESP_SLVERR;
         end
      end
      next_arready = ~next_rvalid;
      // a new event in the clearing cycle survives the clear
      next_event_q = (event_q & ~rd_clr) | evt_new;
      next_irq = |(next_event_q & next_mask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_tick_en <= plsd_pkg::CTL_TICK_EN_RST;
         mask <= plsd_pkg::MASK_RST;
         event_q <= plsd_pkg::EVENT_RST;
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h0000_0000;
         w_lane0 <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= plsd_pkg::RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= plsd_pkg::RESP_OKAY;
         irq <= 1'b0;
      end else begin
         ctl_tick_en <= next_ctl_tick_en;
         mask <= next_mask;
         event_q <= next_event_q;
         aw_have <= next_aw_have;
         w_have <= next_w_have;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_lane0 <= next_w_lane0;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
         irq <= next_irq;
      end
   end

endmodule

// File: dv/plsd_chk.sv
`timescale 1ns/1ps
module plsd_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic cfg_par_err,
   input wire logic rcv_cor_err,
   input wire logic dl_up,
   input wire logic dl_exit_n,
   input wire logic tick_128_nanosecond,
   input wire logic tick_1_microsecond,
   input wire logic hot_reset_exit_n,
   input wire logic l2_exit_n,
   input wire logic [4:0] ltssm_state
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   logic [7:0] us_cnt;
   // ff means no tick yet; a counter, not a 100-deep repeat
   always_ff @(posedge aclk) begin
      if (!aresetn) us_cnt <= 8'hFF;
      else if (tick_1_microsecond) us_cnt <= 8'h00;
      else if (us_cnt != 8'hFF) us_cnt <= us_cnt + 8'h01;
   end
   property p_dl_exit; $fell(dl_up) |-> !dl_exit_n ##1 dl_exit_n; endproperty
   a_dl_exit: assert property (p_dl_exit) else $error("dl exit");
   property p_dl_cause; !dl_exit_n |-> $fell(dl_up); endproperty
   a_dl_cause: assert property (p_dl_cause) else $error("stray exit");
   property p_hot; $past(ltssm_state) == 5'h14 && ltssm_state != 5'h14
      |-> !hot_reset_exit_n ##1 hot_reset_exit_n; endproperty
   a_hot: assert property (p_hot) else $error("hot exit");
   property p_l2; $past(ltssm_state) == 5'h15 && ltssm_state < 5'h02
      |-> !l2_exit_n ##1 l2_exit_n; endproperty
   a_l2: assert property (p_l2) else $error("l2 exit");
   property p_t128; tick_128_nanosecond |=> !tick_128_nanosecond [*8] ##1
      !tick_128_nanosecond [*3] ##1 (tick_128_nanosecond or
      !tick_128_nanosecond ##1 tick_128_nanosecond); endproperty
   a_t128: assert property (p_t128) else $error("short tick");
   property p_t1us; tick_1_microsecond && us_cnt != 8'hFF
      |-> us_cnt == 8'h63; endproperty
   a_t1us: assert property (p_t1us) else $error("long tick");
   property p_rcv; rcv_cor_err |=> !rcv_cor_err; endproperty
   a_rcv: assert property (p_rcv) else $error("rcv pulse");
   property p_par; cfg_par_err |=> cfg_par_err; endproperty
   a_par: assert property (p_par) else $error("parity flag");
endmodule
bind plsd_top plsd_chk i_plsd_chk (.*);

// File: dv/plsd_app_model.sv
`timescale 1ns/1ps
module plsd_app_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic dl_exit_n,
   input wire logic hot_reset_exit_n,
   input wire logic l2_exit_n,
   output logic app_rst
);
   logic [5:0] hold;
   logic any_exit;
   // observes only; error flags steer nothing
   assign any_exit = !(dl_exit_n && hot_reset_exit_n && l2_exit_n);
   always_ff @(posedge aclk) begin
      if (!aresetn) hold <= 6'h00;
      else if (any_exit) hold <= 6'h20;
      else if (hold != 6'h00) hold <= hold - 6'h01;
   end
   assign app_rst = hold != 6'h00;
endmodule

// File: dv/pcie_link_status_debug_outputs_test.sv
`timescale 1ns/1ps
module pcie_link_status_debug_outputs_test;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   plsd_pkg::plsd_core_s core_in = '0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, cfg_par_err, rcv_cor_err, rpl_cor_err, rpl_uncor_err;
   logic dl_up, dl_exit_n, tick_128_nanosecond, tick_1_microsecond, irq;
   logic hot_reset_exit_n, l2_exit_n, app_rst;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0] int_status, lane_act;
   logic [4:0] ltssm_state;
   logic [6:0] ev;
   int err_total = 0, n_compared = 0, c[7] = '{default: 0}, s[7];
   localparam int T8 = 640 * plsd_pkg::CLK_PERIOD_NS / plsd_pkg::TICK_SHORT_NS;
   localparam int T1 = 1000 * plsd_pkg::CLK_PERIOD_NS / plsd_pkg::TICK_LONG_NS;
   always #5 aclk = ~aclk;
   plsd_top i_plsd_top (.*);
   plsd_app_model i_plsd_app_model (.*);
   assign ev = {app_rst, tick_1_microsecond, tick_128_nanosecond, rcv_cor_err,
      !l2_exit_n, !hot_reset_exit_n, !dl_exit_n};
   always @(posedge aclk) foreach (c[i]) c[i] <= c[i] + int'(ev[i]);
   task automatic chk(input logic [31:0] got, exp, input string m);
      n_compared++;
      if (got !== exp) err_total++;
      if (got !== exp) $display("MISMATCH t=%0t %s %h/%h", $time, m, got, exp);
   endtask
   // one access at a time; read compares data against d
   task automatic acc(input logic w, input logic [3:0] a,
      input logic [31:0] d, input logic [1:0] e, input string m);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_arvalid <= !w;
      s_axi_bready <= w;
      s_axi_rready <= !w;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!(w ? s_axi_bvalid : s_axi_rvalid));
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      if (!w) chk(s_axi_rdata, d, m);
      chk(32'(w ? s_axi_bresp : s_axi_rresp), 32'(e), m);
   endtask
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      // whole run is about 12 us
      #50us;
      err_total++;
      $display("MISMATCH t=%0t watchdog", $time);
      finish_test();
   end
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      acc(1'b0, 4'h0, 32'h0, 2'h0, "status");
      acc(1'b0, 4'hC, 32'h1, 2'h0, "control");
      acc(1'b1, 4'h6, 32'h1, 2'h2, "unaligned");
      acc(1'b1, 4'h8, 32'h10, 2'h0, "mask");
      acc(1'b0, 4'h8, 32'h10, 2'h0, "mask");
      s_axi_wstrb <= 4'hE;
      acc(1'b1, 4'h8, 32'h7F, 2'h0, "strobe");
      s_axi_wstrb <= 4'hF;
      acc(1'b0, 4'h8, 32'h10, 2'h0, "strobe");
      $display("test registers done");
      core_in <= '{ltssm: 5'h0F, lane: 4'h8, intx: 4'hA, dl_up: 1'b1, default: '0};
      repeat (6) @(posedge aclk);
      chk(32'(int_status), 32'hA, "intx");
      acc(1'b0, 4'h0, 32'h000A_80F1, 2'h0, "up");
      s = c;
      core_in.dl_up <= 1'b0;
      repeat (6) @(posedge aclk);
      chk(32'(irq), 32'h1, "irq");
      acc(1'b0, 4'h4, 32'h10, 2'h0, "event");
      repeat (2) @(posedge aclk);
      chk(32'(irq), 32'h0, "irq clear");
      repeat (30) @(posedge aclk);
      chk(32'(c[0] - s[0]), 32'h1, "dl exit");
      chk(32'(c[6] - s[6]), 32'h20, "app reset");
      $display("test link done");
      for (int i = 0; i < 3; i++) begin
         core_in.ltssm <= i ? 5'h15 : 5'h14;
         repeat (6) @(posedge aclk);
         s = c;
         core_in.ltssm <= i ? 5'(i - 1) : 5'h0F;
         repeat (7) @(posedge aclk);
         chk(32'(c[1] - s[1]), i ? 32'h0 : 32'h1, "hot");
         chk(32'(c[2] - s[2]), i ? 32'h1 : 32'h0, "l2");
      end
      for (int i = 0; i < 4; i++) begin
         core_in.lane <= 4'(16'h2841 >> (4 * i));
         repeat (6) @(posedge aclk);
         chk(32'(lane_act), 32'(4'(16'h0841 >> (4 * i))), "lane");
      end
      $display("test training done");
      core_in.cfg_par <= 1'b1;
      core_in.rpl_cor <= 1'b1;
      core_in.rcv_cor <= 1'b1;
      s = c;
      repeat (4) @(posedge aclk);
      chk(32'({cfg_par_err, rpl_cor_err, rpl_uncor_err}), 32'h6, "set");
      core_in <= '{ltssm: 5'h01, intx: 4'hA, rpl_uncor: 1'b1, default: '0};
      repeat (6) @(posedge aclk);
      chk(32'({cfg_par_err, rpl_cor_err, rpl_uncor_err}), 32'h5, "err");
      chk(32'(c[3] - s[3]), 32'h1, "rcv");
      acc(1'b0, 4'h4, 32'h6F, 2'h0, "events");
      acc(1'b0, 4'h0, 32'h000A_0012, 2'h0, "sticky");
      $display("test errors done");
      s = c;
      repeat (640) @(posedge aclk);
      chk(32'(c[4] - s[4]), 32'(T8), "tick 128");
      repeat (360) @(posedge aclk);
      chk(32'(c[5] - s[5]), 32'(T1), "tick 1us");
      $display("test ticks done");
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (5) @(posedge aclk);
      chk(32'({cfg_par_err, rpl_uncor_err}), 32'h1, "reset");
      $display("test reset done");
      finish_test();
   end
endmodule
